/* File: logic/lbpc_pkg.sv */
// lo buffer / pll calibration register bank: constants, field layout, reset values
// assumes byte address = 4 x register index on an apb bus with 32-bit data
package lbpc_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_SWING = 6'h18;
   localparam logic [5:0] IDX_CURRENT = 6'h19;
   localparam logic [5:0] IDX_GAIN = 6'h1a;
   localparam logic [5:0] IDX_CAL = 6'h1b;
   localparam logic [5:0] IDX_STATUS = 6'h30;
   // field positions (low bit of each field)
   localparam int PRE_LSB = 6;
   localparam int RX_LSB = 3;
   localparam int TX_LSB = 0;
   localparam int CAL_START_BIT = 7;
   localparam int CAL_DUAL_BIT = 6;
   localparam int CAL_WAIT_LSB = 4;
   localparam int CAL_RSVD_BIT = 3;
   localparam int CAL_DAC_LSB = 0;
   // reset values
   localparam logic [1:0] PRE_SWING_RST = 2'h3;
   localparam logic [2:0] RX_SWING_RST = 3'h4;
   localparam logic [2:0] TX_SWING_RST = 3'h1;
   localparam logic [1:0] PRE_CURRENT_RST = 2'h1;
   localparam logic [2:0] RX_CURRENT_RST = 3'h4;
   localparam logic [2:0] TX_CURRENT_RST = 3'h5;
   localparam logic [7:0] GAIN_RST = 8'h86;
   localparam logic [1:0] CAL_WAIT_RST = 2'h0;
   localparam logic [2:0] CAL_DAC_RST = 3'h5;
   // calibration duration in reference clock periods per wait code
   localparam int CAL_CNT_W = 18;
   localparam int unsigned CAL_WAIT0_TICKS = 90000;
   localparam int unsigned CAL_WAIT1_TICKS = 110000;
   localparam int unsigned CAL_WAIT2_TICKS = 130000;
   localparam int unsigned CAL_WAIT3_TICKS = 200000;
   // status register bits
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_SET_A_BIT = 2;
   localparam int ST_SET_B_BIT = 3;
   // calibration timer states
   typedef enum logic [0:0] {
      LBPC_IDLE,
      LBPC_COUNT
   } lbpc_cal_state_e;
endpackage : lbpc_pkg

/* File: logic/lbpc_cal_if.sv */
// carrier between register bank and calibration timer
// assumes both ends share pclk
`timescale 1ns/1ps
interface lbpc_cal_if;
   logic start;
   logic [1:0] wait_sel;
   logic busy;
   logic done;
   modport ctrl (output start, output wait_sel, input busy, input done);
   modport timer (input start, input wait_sel, output busy, output done);
endinterface : lbpc_cal_if

/* File: logic/lbpc_cal_timer.sv */
// calibration wait timer counted in reference clock periods
// assumes ref_tick is a one-cycle pulse per reference period, synchronous to pclk
`timescale 1ns/1ps
module lbpc_cal_timer #(
   parameter int unsigned W0 = lbpc_pkg::CAL_WAIT0_TICKS,
   parameter int unsigned W1 = lbpc_pkg::CAL_WAIT1_TICKS,
   parameter int unsigned W2 = lbpc_pkg::CAL_WAIT2_TICKS,
   parameter int unsigned W3 = lbpc_pkg::CAL_WAIT3_TICKS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // reference period pulse
   input wire logic ref_tick,
   // control carrier
   lbpc_cal_if.timer cal
);
   localparam int CW = lbpc_pkg::CAL_CNT_W;

   typedef struct packed {
      lbpc_pkg::lbpc_cal_state_e st;
      logic [CW-1:0] cnt;
      logic [CW-1:0] limit;
      logic done;
   } lbpc_tmr_s;

   lbpc_tmr_s q_r;
   lbpc_tmr_s q_nxt;

   // duration lookup; a start while counting is ignored
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      case (q_r.st)
         lbpc_pkg::LBPC_IDLE: begin
            if (cal.start) begin
               q_nxt.st = lbpc_pkg::LBPC_COUNT;
               q_nxt.cnt = '0;
               case (cal.wait_sel)
                  2'h0: q_nxt.limit = CW'(W0);
                  2'h1: q_nxt.limit = CW'(W1);
                  2'h2: q_nxt.limit = CW'(W2);
                  default: q_nxt.limit = CW'(W3);
               endcase
            end
         end
         default: begin
            if (ref_tick) begin
               if (q_r.cnt == q_r.limit - CW'(1)) begin
                  q_nxt.st = lbpc_pkg::LBPC_IDLE;
                  q_nxt.done = 1'b1;
               end else begin
                  q_nxt.cnt = q_r.cnt + CW'(1);
               end
            end
         end
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '{st: lbpc_pkg::LBPC_IDLE, cnt: '0, limit: '0, done: 1'b0};
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   assign cal.busy = (q_r.st == lbpc_pkg::LBPC_COUNT);
   assign cal.done = q_r.done;
endmodule : lbpc_cal_timer

/* File: logic/lbpc_regs.sv */
// lo buffer swing/current, loop gain trim and calibration control register bank
// assumes an apb master on pclk, ref_tick once per reference period,
// and freq_sel driven from the frequency-select bit elsewhere in the device
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module lbpc_regs #(
   parameter int ADDR_W = 8,
   parameter int unsigned CAL_WAIT0_TICKS = lbpc_pkg::CAL_WAIT0_TICKS,
   parameter int unsigned CAL_WAIT1_TICKS = lbpc_pkg::CAL_WAIT1_TICKS,
   parameter int unsigned CAL_WAIT2_TICKS = lbpc_pkg::CAL_WAIT2_TICKS,
   parameter int unsigned CAL_WAIT3_TICKS = lbpc_pkg::CAL_WAIT3_TICKS
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reference timing and frequency set select
   input wire logic ref_tick,
   input wire logic freq_sel,
   // prescaler swing as ratio num/den
   output logic [2:0] pre_swing_num,
   output logic [1:0] pre_swing_den,
   // lo buffer swing codes
   output logic [2:0] rx_swing,
   output logic [2:0] tx_swing,
   // prescaler current as ratio num/den
   output logic [1:0] pre_current_num,
   output logic [2:0] pre_current_den,
   // lo buffer current codes
   output logic [2:0] rx_current,
   output logic [2:0] tx_current,
   // charge pump scaling factor
   output logic [7:0] loop_gain,
   // calibration
   output logic [3:0] dac_start_value,
   output logic cal_busy,
   output logic store_set_a,
   output logic store_set_b
);
   // lint-friendly narrow copies of package positions
   localparam int PL = lbpc_pkg::PRE_LSB;
   localparam int RL = lbpc_pkg::RX_LSB;
   localparam int TL = lbpc_pkg::TX_LSB;

   typedef struct packed {
      logic [7:0] swing;
      logic [7:0] current;
      logic [7:0] gain;
      logic [7:0] cal;
      logic [31:0] rdata;
      logic err;
      logic start_p;
      logic dual_l;
      logic fsel_l;
      logic done_sticky;
      logic last_a;
      logic last_b;
      logic store_a;
      logic store_b;
      logic [2:0] psw_num;
      logic [1:0] psw_den;
      logic [1:0] pcur_num;
      logic [2:0] pcur_den;
      logic [3:0] dac;
   } lbpc_regs_s;

   lbpc_regs_s q_r;
   lbpc_regs_s q_nxt;

   lbpc_cal_if cal_bus ();

   // address decode results
   logic hit_swing;
   logic hit_current;
   logic hit_gain;
   logic hit_cal;
   logic hit_status;
   logic hit_any;
   logic wr_en;
   logic setup;
   logic [7:0] status_v;
   logic [7:0] rd_v;
   logic [7:0] wbyte;

   // aligned word decode; unaligned or unknown addresses raise pslverr
   always_comb begin
      hit_swing = 1'b0;
      hit_current = 1'b0;
      hit_gain = 1'b0;
      hit_cal = 1'b0;
      hit_status = 1'b0;
      if (paddr == ADDR_W'({lbpc_pkg::IDX_SWING, 2'h0})) begin
         hit_swing = 1'b1;
      end else if (paddr == ADDR_W'({lbpc_pkg::IDX_CURRENT, 2'h0})) begin
         hit_current = 1'b1;
      end else if (paddr == ADDR_W'({lbpc_pkg::IDX_GAIN, 2'h0})) begin
         hit_gain = 1'b1;
      end else if (paddr == ADDR_W'({lbpc_pkg::IDX_CAL, 2'h0})) begin
         hit_cal = 1'b1;
      end else if (paddr == ADDR_W'({lbpc_pkg::IDX_STATUS, 2'h0})) begin
         hit_status = 1'b1;
      end
      hit_any = hit_swing | hit_current | hit_gain | hit_cal | hit_status;
   end

   // writes land on the access edge only, low byte lane only
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pstrb[0] & hit_any;
   assign wbyte = pwdata[7:0];

   // status view: busy includes a start still queued for the timer
   always_comb begin
      status_v = 8'h00;
      status_v[lbpc_pkg::ST_BUSY_BIT] = q_r.start_p | cal_bus.busy;
      status_v[lbpc_pkg::ST_DONE_BIT] = q_r.done_sticky;
      status_v[lbpc_pkg::ST_SET_A_BIT] = q_r.last_a;
      status_v[lbpc_pkg::ST_SET_B_BIT] = q_r.last_b;
   end

   // read mux; upper bits of every word read as zero
   always_comb begin
      rd_v = 8'h00;
      if (hit_swing) begin
         rd_v = q_r.swing;
      end else if (hit_current) begin
         rd_v = q_r.current;
      end else if (hit_gain) begin
         rd_v = q_r.gain;
      end else if (hit_cal) begin
         rd_v = q_r.cal;
      end else if (hit_status) begin
         rd_v = status_v;
      end
   end

   // next state of the whole bank
   always_comb begin
      q_nxt = q_r;
      q_nxt.start_p = 1'b0;
      q_nxt.store_a = 1'b0;
      q_nxt.store_b = 1'b0;

      // read data and error are sampled in the setup cycle so the
      // access phase can finish in one cycle with registered data
      if (setup) begin
         q_nxt.rdata = {24'h000000, rd_v};
         q_nxt.err = ~hit_any;
      end

      if (wr_en && hit_swing) begin
         q_nxt.swing = wbyte;
      end
      if (wr_en && hit_current) begin
         q_nxt.current = wbyte;
      end
      if (wr_en && hit_gain) begin
         q_nxt.gain = wbyte;
      end
      if (wr_en && hit_cal) begin
         q_nxt.cal = wbyte;
         // reserved bit is not stored and reads zero
         q_nxt.cal[lbpc_pkg::CAL_RSVD_BIT] = 1'b0;
         // only a 0 to 1 change starts; a start while busy is dropped
         if (wbyte[lbpc_pkg::CAL_START_BIT] && !q_r.cal[lbpc_pkg::CAL_START_BIT] &&
             !q_r.start_p && !cal_bus.busy) begin
            q_nxt.start_p = 1'b1;
            q_nxt.done_sticky = 1'b0;
            // destination fixed at start so a mid-run change cannot split it
            q_nxt.dual_l = wbyte[lbpc_pkg::CAL_DUAL_BIT];
            q_nxt.fsel_l = freq_sel;
         end
      end

      // completion: pulse the chosen set strobes and keep a record
      if (cal_bus.done) begin
         q_nxt.store_a = q_r.dual_l | ~q_r.fsel_l;
         q_nxt.store_b = q_r.dual_l | q_r.fsel_l;
         q_nxt.last_a = q_r.dual_l | ~q_r.fsel_l;
         q_nxt.last_b = q_r.dual_l | q_r.fsel_l;
         q_nxt.done_sticky = 1'b1;
      end

      // prescaler swing ratio: 2/3, 1/2, 4/3, 1/1
      case (q_nxt.swing[PL+:2])
         2'h0: begin
            q_nxt.psw_num = 3'h2;
            q_nxt.psw_den = 2'h3;
         end
         2'h1: begin
            q_nxt.psw_num = 3'h1;
            q_nxt.psw_den = 2'h2;
         end
         2'h2: begin
            q_nxt.psw_num = 3'h4;
            q_nxt.psw_den = 2'h3;
         end
         default: begin
            q_nxt.psw_num = 3'h1;
            q_nxt.psw_den = 2'h1;
         end
      endcase

      // prescaler current ratio: 1/1, 2/3, 1/2, 2/5
      case (q_nxt.current[PL+:2])
         2'h0: begin
            q_nxt.pcur_num = 2'h1;
            q_nxt.pcur_den = 3'h1;
         end
         2'h1: begin
            q_nxt.pcur_num = 2'h2;
            q_nxt.pcur_den = 3'h3;
         end
         2'h2: begin
            q_nxt.pcur_num = 2'h1;
            q_nxt.pcur_den = 3'h2;
         end
         default: begin
            q_nxt.pcur_num = 2'h2;
            q_nxt.pcur_den = 3'h5;
         end
      endcase

      // dac start value is the code plus one, 1 to 8
      q_nxt.dac = {1'b0, q_nxt.cal[lbpc_pkg::CAL_DAC_LSB+:3]} + 4'h1;
   end

   // bank register; ce low freezes everything, bus included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '{
            swing: {lbpc_pkg::PRE_SWING_RST, lbpc_pkg::RX_SWING_RST,
                    lbpc_pkg::TX_SWING_RST},
            current: {lbpc_pkg::PRE_CURRENT_RST, lbpc_pkg::RX_CURRENT_RST,
                      lbpc_pkg::TX_CURRENT_RST},
            gain: lbpc_pkg::GAIN_RST,
            cal: {2'h0, lbpc_pkg::CAL_WAIT_RST, 1'b0,
                  lbpc_pkg::CAL_DAC_RST},
            rdata: 32'h00000000,
            err: 1'b0,
            start_p: 1'b0,
            dual_l: 1'b0,
            fsel_l: 1'b0,
            done_sticky: 1'b0,
            last_a: 1'b0,
            last_b: 1'b0,
            store_a: 1'b0,
            store_b: 1'b0,
            psw_num: 3'h1,
            psw_den: 2'h1,
            pcur_num: 2'h2,
            pcur_den: 3'h3,
            dac: 4'h6
         };
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   // timer is told the wait code current at the moment the start is issued
   assign cal_bus.start = q_r.start_p;
   assign cal_bus.wait_sel = q_r.cal[lbpc_pkg::CAL_WAIT_LSB+:2];

   lbpc_cal_timer #(
      .W0(CAL_WAIT0_TICKS),
      .W1(CAL_WAIT1_TICKS),
      .W2(CAL_WAIT2_TICKS),
      .W3(CAL_WAIT3_TICKS)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .ref_tick(ref_tick),
      .cal(cal_bus.timer)
   );

   // apb answer: one access cycle whenever ce is high
   assign pready = ce;
   assign pslverr = psel & penable & q_r.err;
   assign prdata = q_r.rdata;

   // analog-facing settings straight from flops, cal_busy from the status view
   assign pre_swing_num = q_r.psw_num;
   assign pre_swing_den = q_r.psw_den;
   assign rx_swing = q_r.swing[RL+:3];
   assign tx_swing = q_r.swing[TL+:3];
   assign pre_current_num = q_r.pcur_num;
   assign pre_current_den = q_r.pcur_den;
   assign rx_current = q_r.current[RL+:3];
   assign tx_current = q_r.current[TL+:3];
   assign loop_gain = q_r.gain;
   assign dac_start_value = q_r.dac;
   assign cal_busy = status_v[lbpc_pkg::ST_BUSY_BIT];
   assign store_set_a = q_r.store_a;
   assign store_set_b = q_r.store_b;
endmodule : lbpc_regs

/* File: testbench/lbpc_regs_checker.sv */
// checker for the lo buffer / loop gain / calibration register bank
// assumes it is bound to lbpc_regs and sees only its ports
`timescale 1ns/1ps
module lbpc_regs_checker #(
   parameter int ADDR_W = 8,
   parameter int unsigned CAL_WAIT0_TICKS = 5,
   parameter int unsigned CAL_WAIT1_TICKS = 6,
   parameter int unsigned CAL_WAIT2_TICKS = 7,
   parameter int unsigned CAL_WAIT3_TICKS = 10
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb request side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic ref_tick,
   // decoded settings
   input wire logic [2:0] pre_swing_num,
   input wire logic [1:0] pre_swing_den,
   input wire logic [2:0] rx_swing,
   input wire logic [2:0] tx_swing,
   input wire logic [1:0] pre_current_num,
   input wire logic [2:0] pre_current_den,
   input wire logic [2:0] rx_current,
   input wire logic [2:0] tx_current,
   input wire logic [7:0] loop_gain,
   // calibration
   input wire logic [3:0] dac_start_value,
   input wire logic cal_busy,
   input wire logic store_set_a,
   input wire logic store_set_b
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ratio tables as {num, den} per code
   localparam logic [4:0] SW_TAB [4] = '{5'h0b, 5'h06, 5'h13, 5'h05};
   localparam logic [4:0] CU_TAB [4] = '{5'h09, 5'h13, 5'h0a, 5'h15};
   logic wr;
   logic go;
   logic st_r;
   logic [1:0] wsel_r;
   logic [17:0] tick_r;
   // a start is only taken on a rising start bit while idle
   assign wr = psel && penable && pwrite && ce && pstrb[0];
   assign go = wr && paddr == 8'h6c && pwdata[7] && !st_r && !cal_busy;
   function automatic int unsigned wait_n(input logic [1:0] c);
      return c == 2'h0 ? CAL_WAIT0_TICKS : c == 2'h1 ? CAL_WAIT1_TICKS :
             c == 2'h2 ? CAL_WAIT2_TICKS : CAL_WAIT3_TICKS;
   endfunction : wait_n
   // shadow of the start bit, wait code and ticks seen while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= 1'b0;
         wsel_r <= 2'h0;
         tick_r <= '0;
      end else begin
         if (wr && paddr == 8'h6c) st_r <= pwdata[7];
         if (go) wsel_r <= pwdata[5:4];
         tick_r <= !cal_busy ? '0 : tick_r + 18'((ref_tick && ce) ? 1 : 0);
      end
   end
   property p_pre_swing;
      wr && paddr == 8'h60 |=> {pre_swing_num, pre_swing_den} == SW_TAB[$past(pwdata[7:6])];
   endproperty
   a_pre_swing: assert property (p_pre_swing) else $error("prescaler swing wrong");
   property p_swing_fields;
      wr && paddr == 8'h60 |=> rx_swing == $past(pwdata[5:3]) && tx_swing == $past(pwdata[2:0]);
   endproperty
   a_swing_fields: assert property (p_swing_fields) else $error("buffer swing wrong");
   property p_pre_current;
      wr && paddr == 8'h64 |=> {pre_current_num, pre_current_den} == CU_TAB[$past(pwdata[7:6])];
   endproperty
   a_pre_current: assert property (p_pre_current) else $error("prescaler current wrong");
   property p_cur_fields;
      wr && paddr == 8'h64 |=> rx_current == $past(pwdata[5:3]) && tx_current == $past(pwdata[2:0]);
   endproperty
   a_cur_fields: assert property (p_cur_fields) else $error("buffer current wrong");
   property p_gain;
      wr && paddr == 8'h68 |=> loop_gain == $past(pwdata[7:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("loop gain wrong");
   property p_dac;
      wr && paddr == 8'h6c |=> dac_start_value == {1'b0, $past(pwdata[2:0])} + 4'h1;
   endproperty
   a_dac: assert property (p_dac) else $error("dac start value wrong");
   property p_start;
      go |=> cal_busy [*2];
   endproperty
   a_start: assert property (p_start) else $error("calibration did not start");
   property p_wait;
      $fell(cal_busy) |-> tick_r == wait_n(wsel_r);
   endproperty
   a_wait: assert property (p_wait) else $error("calibration length wrong");
   property p_store_end;
      $fell(cal_busy) |=> store_set_a || store_set_b;
   endproperty
   a_store_end: assert property (p_store_end) else $error("no result store");
   property p_store_pulse;
      store_set_a || store_set_b |=> !store_set_a && !store_set_b;
   endproperty
   a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");
   c_start: cover property (go);
   c_dual: cover property (store_set_a && store_set_b);
   c_wait3: cover property ($fell(cal_busy) && wsel_r == 2'h3);
endmodule : lbpc_regs_checker

bind lbpc_regs lbpc_regs_checker #(.ADDR_W(ADDR_W), .CAL_WAIT0_TICKS(CAL_WAIT0_TICKS),
   .CAL_WAIT1_TICKS(CAL_WAIT1_TICKS), .CAL_WAIT2_TICKS(CAL_WAIT2_TICKS),
   .CAL_WAIT3_TICKS(CAL_WAIT3_TICKS)) i_lbpc_regs_checker (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .ref_tick(ref_tick), .pre_swing_num(pre_swing_num),
   .pre_swing_den(pre_swing_den), .rx_swing(rx_swing), .tx_swing(tx_swing),
   .pre_current_num(pre_current_num), .pre_current_den(pre_current_den),
   .rx_current(rx_current), .tx_current(tx_current), .loop_gain(loop_gain),
   .dac_start_value(dac_start_value), .cal_busy(cal_busy), .store_set_a(store_set_a),
   .store_set_b(store_set_b));

/* File: testbench/tb_top.sv */
// self-checking bench for the register bank, apb master and reference ticks
// assumes shortened calibration waits of 5, 6, 7 and 10 ticks
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn, ce, psel, penable, pwrite, ref_tick, freq_sel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic pready, pslverr, err, cal_busy, store_set_a, store_set_b;
   logic [2:0] pre_swing_num, rx_swing, tx_swing, pre_current_den, rx_current, tx_current;
   logic [1:0] pre_swing_den, pre_current_num;
   logic [7:0] loop_gain;
   logic [3:0] dac_start_value;
   int n_mismatch = 0;
   int n_checks = 0;
   // 20 mhz
   always #25 pclk = ~pclk;
   lbpc_regs #(.ADDR_W(8), .CAL_WAIT0_TICKS(5), .CAL_WAIT1_TICKS(6), .CAL_WAIT2_TICKS(7),
      .CAL_WAIT3_TICKS(10)) i_lbpc_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_tick(ref_tick),
      .freq_sel(freq_sel), .pre_swing_num(pre_swing_num), .pre_swing_den(pre_swing_den),
      .rx_swing(rx_swing), .tx_swing(tx_swing), .pre_current_num(pre_current_num),
      .pre_current_den(pre_current_den), .rx_current(rx_current), .tx_current(tx_current),
      .loop_gain(loop_gain), .dac_start_value(dac_start_value), .cal_busy(cal_busy),
      .store_set_a(store_set_a), .store_set_b(store_set_b));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : apb
   task automatic t_reset();
      apb(0, 8'h60, 0, 4'hf); check(rd, 32'he1);
      apb(0, 8'h64, 0, 4'hf); check(rd, 32'h65);
      apb(0, 8'h68, 0, 4'hf); check(rd, 32'h86);
      apb(0, 8'h6c, 0, 4'hf); check(rd, 32'h05);
      @(negedge pclk);
      check({27'h0, pre_swing_num, pre_swing_den}, 32'h05);
      check({27'h0, pre_current_num, pre_current_den}, 32'h13);
      check({28'h0, dac_start_value}, 32'h6);
      $display("test reset done");
   endtask : t_reset
   // every prescaler code with spread buffer codes
   task automatic t_fields();
      logic [4:0] swt [4] = '{5'h0b, 5'h06, 5'h13, 5'h05};
      logic [4:0] cut [4] = '{5'h09, 5'h13, 5'h0a, 5'h15};
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {2'(i), 3'(i * 7 / 3), 3'(7 - i * 7 / 3)};
         apb(1, 8'h60, {24'h0, v}, 4'hf);
         apb(0, 8'h60, 0, 4'hf); check(rd, {24'h0, v});
         check({27'h0, pre_swing_num, pre_swing_den}, {27'h0, swt[i]});
         check({26'h0, rx_swing, tx_swing}, {26'h0, v[5:0]});
         apb(1, 8'h64, {24'h0, ~v}, 4'hf);
         apb(0, 8'h64, 0, 4'hf); check(rd, {24'h0, ~v});
         check({27'h0, pre_current_num, pre_current_den}, {27'h0, cut[3 - i]});
         check({26'h0, rx_current, tx_current}, {26'h0, ~v[5:0]});
      end
      // recommended lower band then upper band transmit settings
      apb(1, 8'h60, 32'he4, 4'hf);
      apb(1, 8'h64, 32'h62, 4'hf);
      @(negedge pclk);
      check({29'h0, tx_swing}, 32'h4);
      check({29'h0, tx_current}, 32'h2);
      apb(1, 8'h60, 32'he0, 4'hf);
      apb(1, 8'h64, 32'h65, 4'hf);
      @(negedge pclk);
      check({29'h0, tx_swing}, 32'h0);
      check({29'h0, tx_current}, 32'h5);
      $display("test fields done");
   endtask : t_fields
   // write without the low byte lane strobe dropped, then a recommended gain value
   task automatic t_gain();
      apb(1, 8'h68, 32'h11, 4'he);
      apb(0, 8'h68, 0, 4'hf); check(rd, 32'h86);
      apb(1, 8'h68, 32'hae, 4'hf);
      apb(0, 8'h68, 0, 4'hf); check(rd, 32'hae);
      check({24'h0, loop_gain}, 32'hae);
      $display("test gain done");
   endtask : t_gain
   // unmapped, unaligned, read-only and reserved places
   task automatic t_refuse();
      apb(0, 8'h70, 0, 4'hf);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1, 8'h61, 32'h00, 4'hf);
      check({31'h0, err}, 32'h1);
      apb(1, 8'hc0, 32'hff, 4'hf);
      check({31'h0, err}, 32'h0);
      apb(1, 8'h6c, 32'h0f, 4'hf);
      apb(0, 8'h6c, 0, 4'hf); check(rd, 32'h07);
      check({28'h0, dac_start_value}, 32'h8);
      $display("test refuse done");
   endtask : t_refuse
   // one calibration; code 1 also tries a restart while busy, code 2 a frozen tick
   task automatic t_cal(input logic [1:0] w, input logic dual, input logic fs);
      int nt [4] = '{5, 6, 7, 10};
      logic [7:0] c;
      logic [1:0] e;
      int n;
      c = {1'b0, dual, w, 4'h4};
      e = dual ? 2'h3 : (fs ? 2'h2 : 2'h1);
      freq_sel <= fs;
      apb(1, 8'h6c, {24'h0, c}, 4'hf);
      apb(1, 8'h6c, {24'h0, c | 8'h80}, 4'hf);
      @(negedge pclk); check({31'h0, cal_busy}, 32'h1);
      if (w == 2'h1) begin
         apb(1, 8'h6c, {24'h0, c}, 4'hf);
         apb(1, 8'h6c, {24'h0, c | 8'h80}, 4'hf);
      end
      if (w == 2'h2) begin
         @(posedge pclk); ce <= 1'b0; ref_tick <= 1'b1;
         @(posedge pclk); ce <= 1'b1; ref_tick <= 1'b0;
      end
      for (int i = 0; i < nt[w]; i++) begin
         if (i == nt[w] - 1) begin
            @(negedge pclk); check({31'h0, cal_busy}, 32'h1);
         end
         @(posedge pclk); ref_tick <= 1'b1;
         @(posedge pclk); ref_tick <= 1'b0;
      end
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (!(store_set_a || store_set_b) && n < 8);
      check({30'h0, store_set_b, store_set_a}, {30'h0, e});
      apb(0, 8'hc0, 0, 4'hf); check(rd, {28'h0, e, 2'h2});
      apb(1, 8'h6c, {24'h0, c}, 4'hf);
      $display("test calibration code %0d done", w);
   endtask : t_cal
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      ref_tick = 1'b0;
      freq_sel = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_gain();
      t_refuse();
      t_cal(2'h0, 1'b0, 1'b0);
      t_cal(2'h1, 1'b0, 1'b1);
      t_cal(2'h2, 1'b1, 1'b0);
      t_cal(2'h3, 1'b0, 1'b0);
      tally_and_finish();
   end
endmodule : tb_top
